// File: hw/ctr_consts.svh
// ctr_consts.svh: offsets, field positions, reset values of the 16-bit counter block
// assumes: included by bare name from the package and design files
`ifndef CTR_CONSTS_SVH
`define CTR_CONSTS_SVH
// register indices; each register is one word, byte address is four times the index
`define CTR_OFF_INTCTL 6'h0B
`define CTR_OFF_CTL 6'h10
`define CTR_OFF_LOW 6'h0E
`define CTR_OFF_HIGH 6'h0F
`define CTR_OFF_FLAG 6'h0C
`define CTR_OFF_EN 6'h0D
`define CTR_OFF_IRQ_STAT 6'h11
`define CTR_OFF_IRQ_MASK 6'h12
`define CTR_OFF_MISC 6'h13
// byte addresses seen on the register bus
`define CTR_ADDR_INTCTL 8'h2C
`define CTR_ADDR_FLAG 8'h30
`define CTR_ADDR_EN 8'h34
`define CTR_ADDR_LOW 8'h38
`define CTR_ADDR_HIGH 8'h3C
`define CTR_ADDR_CTL 8'h40
`define CTR_ADDR_IRQ_STAT 8'h44
`define CTR_ADDR_IRQ_MASK 8'h48
`define CTR_ADDR_MISC 8'h4C
`define CTR_ADDR_UNMAPPED 8'hFC
`define CTR_BIT_GIE 7
`define CTR_BIT_PERIPHERAL_IRQ_ENABLE 6
`define CTR_BIT_OVF 0
`define CTR_BIT_ON 0
`define CTR_BIT_CS 1
`define CTR_BIT_SYNCDIS 2
`define CTR_BIT_OSCEN 3
`define CTR_BIT_PS_LO 4
`define CTR_BIT_GATE_EN 6
`define CTR_RST_BYTE 8'h00
`define CTR_MAX_COUNT 16'hFFFF
`define CTR_AXI_OKAY 2'b00
`define CTR_AXI_SLVERR 2'b10
`endif

// File: hw/ctr_pkg.sv
// ctr_pkg.sv: types of the gated 16-bit counter block
// assumes: consts header is on the include path
`include "ctr_consts.svh"
package ctr_pkg;
  typedef struct packed {
    logic gate_en;
    logic [1:0] prescale_select;
    logic osc_en;
    logic sync_disable;
    logic ext_sel;
    logic counter_enable;
  } ctr_ctl_s;
  typedef struct packed {
    logic count_clock_pin;
    logic crystal_clock;
    logic count_gate_n;
    logic internal_oscillator_no_clock_output_pin;
  } ctr_pins_s;
  typedef enum logic [1:0] {ctr_wait_fall, ctr_armed} ctr_edge_e;
endpackage : ctr_pkg

// File: hw/ctr_edge_det.sv
// ctr_edge_det.sv: rising edge finder for the external count clock
// assumes: raw input is synchronous or async; sync path uses two flops
`timescale 1ns/1ps
module ctr_edge_det (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic raw,
  input wire logic sync_disable,
  input wire logic clear_arm,
  output logic rise
);
  logic s1_r, s2_r, prev_r;
  ctr_pkg::ctr_edge_e st_r;
  wire logic smp = sync_disable ? raw : s2_r;
  // two-flop synchroniser, then edge history
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      prev_r <= 1'b0;
      st_r <= ctr_pkg::ctr_wait_fall;
    end else if (ce) begin
      s1_r <= raw;
      s2_r <= s1_r;
      prev_r <= smp;
      if (clear_arm) st_r <= ctr_pkg::ctr_wait_fall;
      else if (prev_r && !smp) st_r <= ctr_pkg::ctr_armed;
    end
  end
  // first rising edge counts only after a falling edge was seen
  assign rise = (st_r == ctr_pkg::ctr_armed) && !prev_r && smp;
endmodule : ctr_edge_det

// File: hw/ctr_prescaler.sv
// ctr_prescaler.sv: hidden divide-by 1/2/4/8 in front of the counter
// assumes: tick pulses are one cycle wide
`timescale 1ns/1ps
module ctr_prescaler #(
  parameter int PS_W = 3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] prescale_select,
  output logic out_tick
);
  // refuse a counter too narrow for the 1:8 ratio
  if (PS_W < 3) begin : g_ps_w_check
    $error("prescaler too narrow");
  end
  logic [PS_W-1:0] cnt_r;
  wire logic [PS_W-1:0] lim = PS_W'((1 << prescale_select) - 1);
  // count ticks, emit one per ratio
  always_ff @(posedge clock) begin
    if (!resetn) cnt_r <= '0;
    else if (ce) begin
      if (clear) cnt_r <= '0;
      else if (tick) cnt_r <= (cnt_r >= lim) ? '0 : cnt_r + 1'b1;
    end
  end
  assign out_tick = tick && (cnt_r >= lim) && !clear;
endmodule : ctr_prescaler

// File: hw/ctr_top.sv
// ctr_top.sv: gated 16-bit timer/counter with AXI4-Lite register slave
// assumes: single clock at 200 MHz, pins synchronous unless sync disabled
`timescale 1ns/1ps
`include "ctr_consts.svh"
module ctr_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic instr_tick,
  input wire logic sleep,
  input wire ctr_pkg::ctr_pins_s pins,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic overflow_irq,
  output logic wake
);
  // register state
  logic [15:0] count_r;
  ctr_pkg::ctr_ctl_s ctl_r;
  logic [7:0] intctl_r;
  logic flag_r, en_r;
  logic [1:0] stat_r, mask_r;
  logic [7:0] awaddr_r;
  logic aw_have_r, w_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  // write channel capture, either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_do = aw_have_r && w_have_r;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
    end
  end
  // register index is the byte address over four
  wire logic [5:0] wa = awaddr_r[7:2];
  wire logic wbyte = wstrb_r[0];
  wire logic [7:0] wd = wdata_r[7:0];
  wire logic wr_low = wr_do && wbyte && wa == `CTR_OFF_LOW;
  wire logic wr_high = wr_do && wbyte && wa == `CTR_OFF_HIGH;
  wire logic wr_ctl = wr_do && wbyte && wa == `CTR_OFF_CTL;
  wire logic wr_int = wr_do && wbyte && wa == `CTR_OFF_INTCTL;
  wire logic wr_flag = wr_do && wbyte && wa == `CTR_OFF_FLAG;
  wire logic wr_en = wr_do && wbyte && wa == `CTR_OFF_EN;
  wire logic wr_stat = wr_do && wbyte && wa == `CTR_OFF_IRQ_STAT;
  wire logic wr_mask = wr_do && wbyte && wa == `CTR_OFF_IRQ_MASK;
  wire logic wr_hit = wa == `CTR_OFF_LOW || wa == `CTR_OFF_HIGH || wa == `CTR_OFF_CTL ||
    wa == `CTR_OFF_INTCTL || wa == `CTR_OFF_FLAG || wa == `CTR_OFF_EN ||
    wa == `CTR_OFF_IRQ_STAT || wa == `CTR_OFF_IRQ_MASK || wa == `CTR_OFF_MISC;
  // write response
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CTR_AXI_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `CTR_AXI_OKAY : `CTR_AXI_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  // count source selection and gating
  wire logic crystal_ok = ctl_r.osc_en && pins.internal_oscillator_no_clock_output_pin;
  wire logic ext_raw = crystal_ok ? pins.crystal_clock : pins.count_clock_pin;
  wire logic async_mode = ctl_r.ext_sel && ctl_r.sync_disable;
  wire logic ext_rise;
  wire logic byte_wr = wr_low || wr_high;
  ctr_edge_det u_edge (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .raw(ext_raw),
    .sync_disable(ctl_r.sync_disable),
    .clear_arm(!ctl_r.counter_enable),
    .rise(ext_rise)
  );
  wire logic gate_open = !ctl_r.gate_en || !pins.count_gate_n;
  // sync modes stop in sleep; async keeps counting
  wire logic src_tick = ctl_r.ext_sel ? ext_rise && (async_mode || !sleep)
    : instr_tick && !sleep;
  wire logic run_tick = src_tick && gate_open && ctl_r.counter_enable;
  wire logic inc;
  ctr_prescaler #(.PS_W(3)) u_ps (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .tick(run_tick),
    .clear(byte_wr),
    .prescale_select(ctl_r.prescale_select),
    .out_tick(inc)
  );
  wire logic wrap = inc && !byte_wr && count_r == `CTR_MAX_COUNT;
  // the counter itself; byte writes win over increments
  always_ff @(posedge clock) begin
    if (!resetn) count_r <= {`CTR_RST_BYTE, `CTR_RST_BYTE};
    else if (ce) begin
      if (wr_low) count_r[7:0] <= wd;
      else if (wr_high) count_r[15:8] <= wd;
      else if (inc) count_r <= count_r + 16'h0001;
    end
  end
  // control registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctl_r <= '0;
      intctl_r <= `CTR_RST_BYTE;
      en_r <= 1'b0;
      mask_r <= 2'b00;
    end else if (ce) begin
      if (wr_ctl) ctl_r <= wd[6:0];
      if (wr_int) intctl_r <= wd;
      if (wr_en) en_r <= wd[`CTR_BIT_OVF];
      if (wr_mask) mask_r <= wd[1:0];
    end
  end
  // overflow flag: set wins over software clear
  always_ff @(posedge clock) begin
    if (!resetn) flag_r <= 1'b0;
    else if (ce) begin
      if (wrap) flag_r <= 1'b1;
      else if (wr_flag) flag_r <= wd[`CTR_BIT_OVF];
    end
  end
  // sticky block status: bit0 overflow, bit1 wake; write one clears
  wire logic wake_ev = wrap && sleep && async_mode;
  wire logic [1:0] stat_set = {wake_ev, wrap};
  always_ff @(posedge clock) begin
    if (!resetn) stat_r <= 2'b00;
    else if (ce) stat_r <= stat_set | (stat_r & ~(wr_stat ? wd[1:0] : 2'b00));
  end
  assign irq = |(stat_r & mask_r);
  assign overflow_irq = flag_r && en_r && intctl_r[`CTR_BIT_PERIPHERAL_IRQ_ENABLE]
    && intctl_r[`CTR_BIT_GIE];
  assign wake = stat_r[1] && sleep;
  // read channel
  wire logic [5:0] ra = s_axi_araddr[7:2];
  wire logic [31:0] rmux =
    ra == `CTR_OFF_LOW ? {24'h00_0000, count_r[7:0]} :
    ra == `CTR_OFF_HIGH ? {24'h00_0000, count_r[15:8]} :
    ra == `CTR_OFF_CTL ? {25'h000_0000, ctl_r} :
    ra == `CTR_OFF_INTCTL ? {24'h00_0000, intctl_r} :
    ra == `CTR_OFF_FLAG ? {31'h0000_0000, flag_r} :
    ra == `CTR_OFF_EN ? {31'h0000_0000, en_r} :
    ra == `CTR_OFF_IRQ_STAT ? {30'h0000_0000, stat_r} :
    ra == `CTR_OFF_IRQ_MASK ? {30'h0000_0000, mask_r} :
    ra == `CTR_OFF_MISC ? {30'h0000_0000, sleep, async_mode} : 32'h0000_0000;
  wire logic rd_hit = ra == `CTR_OFF_LOW || ra == `CTR_OFF_HIGH || ra == `CTR_OFF_CTL ||
    ra == `CTR_OFF_INTCTL || ra == `CTR_OFF_FLAG || ra == `CTR_OFF_EN ||
    ra == `CTR_OFF_IRQ_STAT || ra == `CTR_OFF_IRQ_MASK || ra == `CTR_OFF_MISC;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CTR_AXI_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux;
        s_axi_rresp <= rd_hit ? `CTR_AXI_OKAY : `CTR_AXI_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ctr_top

// File: bench/ctr_top_assertions.sv
// port checker of the gated 16-bit counter block
// assumes: bound onto ctr_top, one clock, ce held high by the bench except in the clock-enable step of the gate test
`timescale 1ns/1ps
`include "ctr_consts.svh"
module ctr_top_assertions (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sleep,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic irq,
  input wire logic overflow_irq,
  input wire logic wake
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // bus answers: timing, holding and refusal
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && ce |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_unmapped: assert property (s_axi_arvalid && s_axi_arready && ce
    && s_axi_araddr == `CTR_ADDR_UNMAPPED
    |=> s_axi_rresp == `CTR_AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // interrupt and wake outputs
  a_wake_sleep: assert property (wake |-> sleep) else $error("wake without sleep");
  a_irq_clear: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq dropped without a write");
  a_ovf_clear: assert property ($fell(overflow_irq) |-> $rose(s_axi_bvalid))
    else $error("overflow request dropped without a write");
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `CTR_AXI_SLVERR);
  c_wake: cover property ($rose(wake));
endmodule : ctr_top_assertions

bind ctr_top ctr_top_assertions i_chk (.clock, .resetn, .ce, .sleep, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .irq, .overflow_irq, .wake);

// File: bench/ctr_pin_model.sv
// model of the external count clock and gate source
// assumes: bench calls its tasks; pins idle high clock, gate open
`timescale 1ns/1ps
module ctr_pin_model (
  input wire logic clock,
  output ctr_pkg::ctr_pins_s pins
);
  // idle: clock pin high, crystal quiet, gate open, internal osc on
  initial pins = 4'h9;
  // one external period, falling edge always first
  task automatic pulse(input int half);
    repeat (half) @(posedge clock);
    pins.count_clock_pin <= 1'h0;
    repeat (half) @(posedge clock);
    pins.count_clock_pin <= 1'h1;
  endtask : pulse
  // one crystal period from its idle low level: rise, then fall
  task automatic xtal(input int half);
    repeat (half) @(posedge clock);
    pins.crystal_clock <= 1'h1;
    repeat (half) @(posedge clock);
    pins.crystal_clock <= 1'h0;
  endtask : xtal
  // static levels, then let the sync path settle
  task automatic level(input logic clk_v, input logic gate_v);
    @(posedge clock);
    pins.count_clock_pin <= clk_v;
    pins.count_gate_n <= gate_v;
    repeat (4) @(posedge clock);
  endtask : level
endmodule : ctr_pin_model

// File: bench/ctr_top_tb_top.sv
// testbench of the gated 16-bit counter block
// assumes: pin model drives pins, bench masters the register bus
`timescale 1ns/1ps
`include "ctr_consts.svh"
module ctr_top_tb_top;
  logic clock = 0, resetn = 0, ce = 1, instr_tick = 0, sleep = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic irq, overflow_irq, wake;
  ctr_pkg::ctr_pins_s pins;
  int bad_count = 0, comparisons = 0;
  always #2.5 clock = ~clock;
  ctr_top i_dut (.clock, .resetn, .ce, .instr_tick, .sleep, .pins, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .overflow_irq, .wake);
  ctr_pin_model i_pins (.clock(clock), .pins(pins));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clock);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      @(posedge clock);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
    end while (!hb);
    s_axi_bready <= 1'h0;
  endtask : wr
  // read with compare of the returned word; only the watchdog ends a hung wait
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic ha, hr;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clock);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clock);
      if (ha) s_axi_arvalid <= 1'h0;
    end while (!hr);
    s_axi_rready <= 1'h0;
    chk(rv, exp);
  endtask : rdc
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      instr_tick <= 1'h1;
      @(posedge clock);
      instr_tick <= 1'h0;
    end
  endtask : tick
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
    rdc(`CTR_ADDR_CTL, 0);
    rdc(`CTR_ADDR_FLAG, 0);
    rdc(`CTR_ADDR_UNMAPPED, 0);
    chk(32'(rr), 32'(`CTR_AXI_SLVERR));
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      wr(`CTR_ADDR_CTL, 32'(1 + 16 * p));
      tick(3);
      wr(`CTR_ADDR_LOW, 0);
      wr(`CTR_ADDR_HIGH, 0);
      tick(16);
      rdc(`CTR_ADDR_LOW, 32'(16 >> p));
    end
    wr(`CTR_ADDR_CTL, 0);
    tick(4);
    rdc(`CTR_ADDR_LOW, 2);
    $display("test prescale done");
    wr(`CTR_ADDR_IRQ_MASK, 0);
    wr(`CTR_ADDR_HIGH, 32'h0000_00ff);
    wr(`CTR_ADDR_LOW, 32'h0000_00ff);
    wr(`CTR_ADDR_CTL, 1);
    tick(1);
    rdc(`CTR_ADDR_HIGH, 0);
    rdc(`CTR_ADDR_FLAG, 1);
    chk(32'(irq), 0);
    wr(`CTR_ADDR_IRQ_MASK, 1);
    chk(32'(irq), 1);
    wr(`CTR_ADDR_EN, 1);
    chk(32'(overflow_irq), 0);
    wr(`CTR_ADDR_INTCTL, 32'h0000_00c0);
    chk(32'(overflow_irq), 1);
    wr(`CTR_ADDR_FLAG, 0);
    chk(32'(overflow_irq), 0);
    wr(`CTR_ADDR_IRQ_STAT, 1);
    chk(32'(irq), 0);
    $display("test overflow done");
    // pin held low while enabling, so its first rise must not count
    for (int s = 0; s < 2; s++) begin
      wr(`CTR_ADDR_CTL, 0);
      i_pins.level(0, 0);
      wr(`CTR_ADDR_LOW, 0);
      wr(`CTR_ADDR_CTL, 32'(3 + 4 * s));
      i_pins.level(1, 0);
      repeat (3) i_pins.pulse(2);
      repeat (4) @(posedge clock);
      rdc(`CTR_ADDR_LOW, 3);
    end
    wr(`CTR_ADDR_HIGH, 32'h0000_00ff);
    wr(`CTR_ADDR_LOW, 32'h0000_00ff);
    @(posedge clock);
    sleep <= 1'h1;
    i_pins.pulse(2);
    repeat (4) @(negedge clock);
    chk(32'(wake), 1);
    @(posedge clock);
    sleep <= 1'h0;
    wr(`CTR_ADDR_IRQ_STAT, 3);
    $display("test external done");
    // crystal selected: its rises count while the count pin stays high
    wr(`CTR_ADDR_CTL, 0);
    wr(`CTR_ADDR_LOW, 0);
    wr(`CTR_ADDR_CTL, 32'h0000_000b);
    repeat (3) i_pins.xtal(2);
    repeat (4) @(posedge clock);
    rdc(`CTR_ADDR_LOW, 3);
    $display("test crystal done");
    wr(`CTR_ADDR_CTL, 32'h0000_0041);
    wr(`CTR_ADDR_LOW, 0);
    i_pins.level(1, 1);
    tick(4);
    rdc(`CTR_ADDR_LOW, 0);
    i_pins.level(1, 0);
    tick(4);
    rdc(`CTR_ADDR_LOW, 4);
    // clock enable low freezes the counter
    @(posedge clock);
    ce <= 1'h0;
    tick(4);
    @(posedge clock);
    ce <= 1'h1;
    rdc(`CTR_ADDR_LOW, 4);
    $display("test gate done");
    print_verdict;
  end
endmodule : ctr_top_tb_top
